// *** rtl/lasr_regs.sv ***
// Link status, application state handshake, indicator override and configuration registers
module lasr_regs (
   input  wire logic                CLK,
   input  wire logic                RST_N,
   input  wire lasr_pkg::lasr_req_t NET_REQ,
   input  wire lasr_pkg::lasr_req_t HOST_REQ,
   input  wire lasr_pkg::lasr_port_t PORT_STATE,
   input  wire logic [7:0]          HOST_SEL_IN,
   input  wire logic [7:0]          CTRL_CFG_IN,
   input  wire logic                NEW_ERROR,
   input  wire logic                RUN_LED_AUTO,
   input  wire logic                ERR_LED_AUTO,
   input  wire logic [3:0]          RUN_LED_PAT,
   input  wire logic [3:0]          ERR_LED_PAT,
   output logic [15:0]              NET_RDATA,
   output logic [15:0]              HOST_RDATA,
   output logic                     NET_EV_LINK_CLR,
   output logic                     NET_EV_STAT_CLR,
   output logic                     APP_EV_CTRL_CLR,
   output logic [3:0]               STATE_REQ,
   output logic                     ERR_ACK,
   output logic [3:0]               STATE_ACT,
   output logic                     MAILBOX_LOCKED,
   output logic                     RUN_LED,
   output logic                     ERR_LED,
   output logic                     MIRROR_EN,
   output logic                     SYNC_OUT_EN,
   output logic                     LATCH_IN_EN,
   output logic [3:0]               ENH_LINK_EN,
   output logic [7:0]               HOST_SEL
);
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] stat;
      logic [15:0] code;
      logic [7:0]  run_ovr;
      logic [7:0]  err_ovr;
      logic        locked;
      logic [15:0] net_rdata;
      logic [15:0] host_rdata;
      logic        ev_link_clr;
      logic        ev_stat_clr;
      logic        app_ev_clr;
      logic        run_led;
      logic        err_led;
      logic [7:0]  cfg;
      logic [7:0]  sel;
      logic [3:0]  enh;
   } lasr_state_t;

   lasr_state_t st_r;
   lasr_state_t st_nxt;
   logic        ctrl_valid;
   logic        host_valid;
   logic        mirror;
   logic [15:0] link_word;
   logic [7:0]  run_rd;
   logic [7:0]  err_rd;
   logic        net_ctrl_hit;
   logic        host_stat_hit;

   lasr_valid_state u_val_host (
      .code  (HOST_REQ.wdata[3:0]),
      .valid (host_valid)
   );

   lasr_valid_state u_val_net (
      .code  (NET_REQ.wdata[3:0]),
      .valid (ctrl_valid)
   );

   assign mirror = st_r.cfg[lasr_pkg::F_MIRROR];   // [RULE20]

   // Bits 3..0 not in this bank's scope; they read zero
   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_port
         assign link_word[lasr_pkg::F_LINK_LSB + p] = PORT_STATE.link[p];  // [RULE1]
         assign link_word[8 + 2 * p]     = PORT_STATE.loop_closed[p];      // [RULE2]
         assign link_word[9 + 2 * p]     = PORT_STATE.comm_ok[p];          // [RULE3]
      end
   endgenerate
   assign link_word[3:0] = 4'h0;

   // Reads return the live indicator level instead of the stored code
   assign run_rd = {st_r.run_ovr[7:4], 3'b000, st_r.run_led};  // [RULE16]
   assign err_rd = {st_r.err_ovr[7:4], 3'b000, st_r.err_led};  // [RULE16]

   assign net_ctrl_hit  = NET_REQ.wr && NET_REQ.addr == lasr_pkg::ADDR_STATE_CTRL;
   assign host_stat_hit = HOST_REQ.wr && HOST_REQ.addr == lasr_pkg::ADDR_STATE_STAT;

   function automatic logic [15:0] read_mux(input logic [15:0] a, input logic [15:0] lw,
                                            input lasr_state_t s, input logic [7:0] rr,
                                            input logic [7:0] er);
      logic [15:0] v;
      v = 16'h0000;
      unique case (a)
         lasr_pkg::ADDR_LINK_STATUS: v = lw;
         lasr_pkg::ADDR_STATE_CTRL:  v = s.ctrl;
         lasr_pkg::ADDR_STATE_STAT:  v = s.stat;
         lasr_pkg::ADDR_STAT_CODE:   v = s.code;
         lasr_pkg::ADDR_RUN_OVR:     v = {er, rr};
         lasr_pkg::ADDR_HOST_SEL:    v = {s.cfg, s.sel};
         default:                    v = 16'h0000;
      endcase
      return v;
   endfunction

   always_comb begin
      st_nxt             = st_r;
      st_nxt.sel         = HOST_SEL_IN;   // [RULE19]
      st_nxt.cfg         = CTRL_CFG_IN;   // [RULE21] [RULE22]
      // Registered so the per-port enables leave the block glitch free
      st_nxt.enh         = CTRL_CFG_IN[lasr_pkg::F_ELD_LSB +: 4] |
                           {4{CTRL_CFG_IN[lasr_pkg::F_ELD_ALL]}};  // [RULE22]
      st_nxt.net_rdata   = NET_REQ.rd ? read_mux(NET_REQ.addr, link_word, st_r, run_rd, err_rd)
                                      : st_r.net_rdata;
      st_nxt.host_rdata  = HOST_REQ.rd ? read_mux(HOST_REQ.addr, link_word, st_r, run_rd, err_rd)
                                       : st_r.host_rdata;
      st_nxt.ev_link_clr = NET_REQ.rd && NET_REQ.addr == lasr_pkg::ADDR_LINK_STATUS;  // [RULE4]
      st_nxt.ev_stat_clr = NET_REQ.rd && NET_REQ.addr == lasr_pkg::ADDR_STATE_STAT;   // [RULE14]
      st_nxt.app_ev_clr  = HOST_REQ.rd && (HOST_REQ.addr == lasr_pkg::ADDR_STATE_CTRL ||
                                           HOST_REQ.addr == lasr_pkg::ADDR_STATE_CTRL_H); // [RULE10]

      // Host read unlocks; a simultaneous net write relocks only if it was unlocked before (set wins)
      if (st_nxt.app_ev_clr) begin
         st_nxt.locked = 1'b0;   // [RULE8]
      end
      if (net_ctrl_hit && (mirror || !st_r.locked)) begin  // [RULE7] [RULE23]
         st_nxt.ctrl = {NET_REQ.wdata[15:5], NET_REQ.wdata[4:0]};  // [RULE5] [RULE6]
         if (!mirror) begin
            st_nxt.locked = 1'b1;  // [RULE7]
         end else begin
            // Copy request into the actual state, error flag cleared
            st_nxt.stat = {11'h000, 1'b0, NET_REQ.wdata[3:0]};  // [RULE9]
            if (ctrl_valid) begin
               st_nxt.run_ovr[lasr_pkg::F_OVR_EN] = 1'b0;  // [RULE17]
            end
         end
      end

      if (host_stat_hit && !mirror) begin  // [RULE13]
         if (HOST_REQ.be[0]) begin
            st_nxt.stat[7:0] = HOST_REQ.wdata[7:0];  // [RULE11] [RULE12]
         end
         if (HOST_REQ.be[1]) begin
            st_nxt.stat[15:8] = HOST_REQ.wdata[15:8];
         end
         if (host_valid && HOST_REQ.be[0]) begin
            st_nxt.run_ovr[lasr_pkg::F_OVR_EN] = 1'b0;  // [RULE17]
         end
      end

      if (HOST_REQ.wr && HOST_REQ.addr == lasr_pkg::ADDR_STAT_CODE) begin  // [RULE15]
         if (HOST_REQ.be[0]) begin
            st_nxt.code[7:0] = HOST_REQ.wdata[7:0];
         end
         if (HOST_REQ.be[1]) begin
            st_nxt.code[15:8] = HOST_REQ.wdata[15:8];
         end
      end

      // Both sides may write the overrides; network write takes priority
      if (HOST_REQ.wr && HOST_REQ.addr == lasr_pkg::ADDR_RUN_OVR) begin  // [RULE16]
         if (HOST_REQ.be[0]) begin
            st_nxt.run_ovr = HOST_REQ.wdata[7:0];
         end
         if (HOST_REQ.be[1]) begin
            st_nxt.err_ovr = HOST_REQ.wdata[15:8];
         end
      end
      if (NET_REQ.wr && NET_REQ.addr == lasr_pkg::ADDR_RUN_OVR) begin  // [RULE16]
         if (NET_REQ.be[0]) begin
            st_nxt.run_ovr = NET_REQ.wdata[7:0];
         end
         if (NET_REQ.be[1]) begin
            st_nxt.err_ovr = NET_REQ.wdata[15:8];
         end
      end
      if (NEW_ERROR) begin
         st_nxt.err_ovr[lasr_pkg::F_OVR_EN] = 1'b0;  // [RULE18]
      end

      // Pattern generator supplies the flash/blink level for the code
      st_nxt.run_led = st_r.run_ovr[lasr_pkg::F_OVR_EN] ? RUN_LED_PAT[0] : RUN_LED_AUTO;
      st_nxt.err_led = st_r.err_ovr[lasr_pkg::F_OVR_EN] ? ERR_LED_PAT[0] : ERR_LED_AUTO;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r         <= '0;
         st_r.ctrl    <= lasr_pkg::RST_STATE_CTRL;  // [RULE5]
         st_r.stat    <= lasr_pkg::RST_STATE_STAT;  // [RULE11]
         st_r.code    <= lasr_pkg::RST_STAT_CODE;
         st_r.run_ovr <= lasr_pkg::RST_OVR;
         st_r.err_ovr <= lasr_pkg::RST_OVR;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign NET_RDATA       = st_r.net_rdata;
   assign HOST_RDATA      = st_r.host_rdata;
   assign NET_EV_LINK_CLR = st_r.ev_link_clr;
   assign NET_EV_STAT_CLR = st_r.ev_stat_clr;
   assign APP_EV_CTRL_CLR = st_r.app_ev_clr;
   assign STATE_REQ       = st_r.ctrl[3:0];
   assign ERR_ACK         = st_r.ctrl[lasr_pkg::F_ERR_IND];
   assign STATE_ACT       = st_r.stat[3:0];
   assign MAILBOX_LOCKED  = st_r.locked;
   assign RUN_LED         = st_r.run_led;
   assign ERR_LED         = st_r.err_led;
   assign MIRROR_EN       = st_r.cfg[lasr_pkg::F_MIRROR];
   assign SYNC_OUT_EN     = st_r.cfg[lasr_pkg::F_SYNC_EN];
   assign LATCH_IN_EN     = st_r.cfg[lasr_pkg::F_LATCH_EN];
   assign ENH_LINK_EN     = st_r.enh;
   assign HOST_SEL        = st_r.sel;
endmodule

// *** rtl/lasr_pkg.sv ***
// Package: register map, field layout and reset values of the link and state register bank
// Overview of operation
// RULE1: Status bits 4..7 show port link detected
// RULE2: Bits 8,10,12,14 show port loop closed
// RULE3: Bits 9,11,13,15 show stable port communication
// RULE4: Network read of link status clears event bit 2
// RULE5: Network writes state request code, reset Init
// RULE6: Network writes bit 4 to acknowledge error
// RULE7: Mirroring off: locked after network write until host read
// RULE8: Unlocked after reset; host read of either byte unlocks
// RULE9: Mirroring on: always writable, copied to status
// RULE10: Host read of control clears application event bit 0
// RULE11: Status low nibble reports actual state, reset Init
// RULE12: Status bit 4 flags unreached or locally changed state
// RULE13: Host writes status only when mirroring off
// RULE14: Network read of status clears event bit 3
// RULE15: Status code host writable, network read only, reset 0
// RULE16: Indicator override code, enable bit, reads show output
// RULE17: Valid status write clears RUN override enable
// RULE18: New error clears ERR override enable
// RULE19: Host interface select field chooses local interface
// RULE20: Config bit 0 selects state mirroring
// RULE21: Config bits 2,3 enable sync out, latch in
// RULE22: Config bit 1 all ports, bits 4..7 per-port enhanced link
// RULE23: Locked mailbox silently discards network write
package lasr_pkg;
   localparam logic [15:0] ADDR_LINK_STATUS   = 16'h0110;
   localparam logic [15:0] ADDR_LINK_STATUS_H = 16'h0111;
   localparam logic [15:0] ADDR_STATE_CTRL    = 16'h0120;
   localparam logic [15:0] ADDR_STATE_CTRL_H  = 16'h0121;
   localparam logic [15:0] ADDR_STATE_STAT    = 16'h0130;
   localparam logic [15:0] ADDR_STATE_STAT_H  = 16'h0131;
   localparam logic [15:0] ADDR_STAT_CODE     = 16'h0134;
   localparam logic [15:0] ADDR_STAT_CODE_H   = 16'h0135;
   localparam logic [15:0] ADDR_RUN_OVR       = 16'h0138;
   localparam logic [15:0] ADDR_ERR_OVR       = 16'h0139;
   localparam logic [15:0] ADDR_HOST_SEL      = 16'h0140;
   localparam logic [15:0] ADDR_CTRL_CFG      = 16'h0141;

   localparam logic [3:0] ST_INIT    = 4'h1;
   localparam logic [3:0] ST_PREOP   = 4'h2;
   localparam logic [3:0] ST_BOOT    = 4'h3;
   localparam logic [3:0] ST_SAFEOP  = 4'h4;
   localparam logic [3:0] ST_OP      = 4'h8;

   localparam int F_ERR_IND   = 4;
   localparam int F_OVR_EN    = 4;
   localparam int F_LINK_LSB  = 4;
   localparam int F_MIRROR    = 0;
   localparam int F_ELD_ALL   = 1;
   localparam int F_SYNC_EN   = 2;
   localparam int F_LATCH_EN  = 3;
   localparam int F_ELD_LSB   = 4;
   localparam int EV_NET_LINK = 2;
   localparam int EV_NET_STAT = 3;

   localparam logic [15:0] RST_STATE_CTRL = 16'h0001;
   localparam logic [15:0] RST_STATE_STAT = 16'h0001;
   localparam logic [15:0] RST_STAT_CODE  = 16'h0000;
   localparam logic [7:0]  RST_OVR        = 8'h00;

   localparam logic [7:0] HS_NONE   = 8'h00;
   localparam logic [7:0] HS_DIO    = 8'h04;
   localparam logic [7:0] HS_SPI    = 8'h05;
   localparam logic [7:0] HS_BRIDGE = 8'h07;
   localparam logic [7:0] HS_ASY16  = 8'h08;
   localparam logic [7:0] HS_ASY8   = 8'h09;
   localparam logic [7:0] HS_SYN16  = 8'h0A;
   localparam logic [7:0] HS_SYN8   = 8'h0B;
   localparam logic [7:0] HS_BUS    = 8'h80;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [1:0]  be;
      logic [15:0] wdata;
   } lasr_req_t;

   typedef struct packed {
      logic [3:0] link;
      logic [3:0] loop_closed;
      logic [3:0] comm_ok;
   } lasr_port_t;
endpackage

// *** rtl/lasr_valid_state.sv ***
// Decoder telling whether a state code is one of the defined states
module lasr_valid_state (
   input  wire logic [3:0] code,
   output logic            valid
);
   always_comb begin
      unique case (code)
         lasr_pkg::ST_INIT, lasr_pkg::ST_PREOP, lasr_pkg::ST_BOOT,
         lasr_pkg::ST_SAFEOP, lasr_pkg::ST_OP: valid = 1'b1;
         default:                              valid = 1'b0;
      endcase
   end
endmodule

// *** sim/lasr_regs_assertions.sv ***
// Port-level checks for the link and state register bank
module lasr_regs_assertions (
   input wire logic                 CLK,
   input wire logic                 RST_N,
   input wire lasr_pkg::lasr_req_t  NET_REQ,
   input wire lasr_pkg::lasr_req_t  HOST_REQ,
   input wire lasr_pkg::lasr_port_t PORT_STATE,
   input wire logic [7:0]           HOST_SEL_IN,
   input wire logic [7:0]           CTRL_CFG_IN,
   input wire logic [15:0]          NET_RDATA,
   input wire logic                 NET_EV_LINK_CLR,
   input wire logic                 NET_EV_STAT_CLR,
   input wire logic                 APP_EV_CTRL_CLR,
   input wire logic [3:0]           STATE_REQ,
   input wire logic [3:0]           STATE_ACT,
   input wire logic                 MAILBOX_LOCKED,
   input wire logic                 MIRROR_EN,
   input wire logic                 SYNC_OUT_EN,
   input wire logic                 LATCH_IN_EN,
   input wire logic [3:0]           ENH_LINK_EN,
   input wire logic [7:0]           HOST_SEL
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        nw_ctrl;
   logic        hr_ctrl;
   logic        hw_stat;
   logic [11:0] link_exp;
   assign nw_ctrl = NET_REQ.wr && NET_REQ.addr == 16'h0120;
   assign hr_ctrl = HOST_REQ.rd && (HOST_REQ.addr == 16'h0120 || HOST_REQ.addr == 16'h0121);
   assign hw_stat = HOST_REQ.wr && HOST_REQ.be[0] && HOST_REQ.addr == 16'h0130;
   always_comb begin
      link_exp[3:0] = PORT_STATE.link;
      for (int p = 0; p < 4; p++) begin
         link_exp[4+2*p] = PORT_STATE.loop_closed[p];
         link_exp[5+2*p] = PORT_STATE.comm_ok[p];
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_link_bits: assert property (NET_REQ.rd && NET_REQ.addr == 16'h0110
      |=> NET_RDATA[15:4] == $past(link_exp)) else $error("link status bits wrong");
   a_link_ev_clr: assert property (NET_EV_LINK_CLR ==
      $past(NET_REQ.rd && NET_REQ.addr == 16'h0110)) else $error("link event clear wrong");
   a_stat_ev_clr: assert property (NET_EV_STAT_CLR ==
      $past(NET_REQ.rd && NET_REQ.addr == 16'h0130)) else $error("status event clear wrong");
   a_app_ev_clr: assert property (APP_EV_CTRL_CLR == $past(hr_ctrl))
      else $error("app event clear wrong");
   a_mbox_lock: assert property (!MIRROR_EN && nw_ctrl && !MAILBOX_LOCKED
      |=> MAILBOX_LOCKED && STATE_REQ == $past(NET_REQ.wdata[3:0])) else $error("lock wrong");
   a_mbox_discard: assert property (!MIRROR_EN && MAILBOX_LOCKED && nw_ctrl
      && !hr_ctrl |=> $stable(STATE_REQ)) else $error("locked write taken");
   a_mbox_unlock: assert property (MAILBOX_LOCKED && hr_ctrl && !nw_ctrl
      |=> !MAILBOX_LOCKED) else $error("host read left lock");
   a_mirror_copy: assert property (MIRROR_EN && nw_ctrl
      |=> STATE_ACT == $past(NET_REQ.wdata[3:0])) else $error("mirror copy wrong");
   a_host_stat: assert property (!MIRROR_EN && hw_stat
      |=> STATE_ACT == $past(HOST_REQ.wdata[3:0])) else $error("host status write lost");
   a_stat_refuse: assert property (MIRROR_EN && hw_stat && !nw_ctrl
      |=> $stable(STATE_ACT)) else $error("host status write taken");
   a_cfg_follow: assert property ($past(RST_N) |->
      {ENH_LINK_EN, LATCH_IN_EN, SYNC_OUT_EN, MIRROR_EN, HOST_SEL} ==
      $past({CTRL_CFG_IN[7:4] | {4{CTRL_CFG_IN[1]}}, CTRL_CFG_IN[3:2], CTRL_CFG_IN[0],
      HOST_SEL_IN})) else $error("config outputs wrong");
endmodule
bind lasr_regs lasr_regs_assertions chk (.CLK(CLK), .RST_N(RST_N), .NET_REQ(NET_REQ),
   .HOST_REQ(HOST_REQ), .PORT_STATE(PORT_STATE), .HOST_SEL_IN(HOST_SEL_IN),
   .CTRL_CFG_IN(CTRL_CFG_IN), .NET_RDATA(NET_RDATA), .NET_EV_LINK_CLR(NET_EV_LINK_CLR),
   .NET_EV_STAT_CLR(NET_EV_STAT_CLR), .APP_EV_CTRL_CLR(APP_EV_CTRL_CLR),
   .STATE_REQ(STATE_REQ), .STATE_ACT(STATE_ACT), .MAILBOX_LOCKED(MAILBOX_LOCKED),
   .MIRROR_EN(MIRROR_EN), .SYNC_OUT_EN(SYNC_OUT_EN), .LATCH_IN_EN(LATCH_IN_EN),
   .ENH_LINK_EN(ENH_LINK_EN), .HOST_SEL(HOST_SEL));

// *** sim/lasr_far_model.sv ***
// Network master and local host model driving both access ports
module lasr_far_model (
   input  wire logic          CLK,
   input  wire logic [15:0]   NET_RDATA,
   input  wire logic [15:0]   HOST_RDATA,
   output lasr_pkg::lasr_req_t NET_REQ,
   output lasr_pkg::lasr_req_t HOST_REQ
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      NET_REQ = '0;
      HOST_REQ = '0;
   end
   // Idle bus shows inverted leftovers so stale values are never trusted
   task automatic acc(input logic net, input logic wr, input logic [15:0] a,
                      input logic [1:0] be, input logic [15:0] d, output logic [15:0] q);
      lasr_pkg::lasr_req_t r;
      r = '{rd: !wr, wr: wr, addr: a, be: be, wdata: d};
      @(posedge CLK);
      #1;
      if (net) NET_REQ = r; else HOST_REQ = r;
      @(posedge CLK);
      #1;
      q = net ? NET_RDATA : HOST_RDATA;
      r = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~be, wdata: ~d};
      if (net) NET_REQ = r; else HOST_REQ = r;
   endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the link and state register bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, new_err, run_auto, err_auto, err_ack, locked, run_led, err_led;
   logic mirror, sync_en, latch_en, lclr, sclr, aclr;
   lasr_pkg::lasr_req_t net_req, host_req;
   lasr_pkg::lasr_port_t port_st;
   logic [7:0] sel_in, cfg_in, sel;
   logic [15:0] net_rd, host_rd, q;
   logic [3:0] st_req, st_act, enh, pat;
   int n_errors = 0;
   int checks = 0;
   logic [7:0] codes [9] = '{8'h00, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h80};
   logic [3:0] sts [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
   logic [11:0] pats [3] = '{12'hA5C, 12'h5A3, 12'hF0F};
   lasr_regs dut (.CLK(clk), .RST_N(rst_n), .NET_REQ(net_req), .HOST_REQ(host_req),
      .PORT_STATE(port_st), .HOST_SEL_IN(sel_in), .CTRL_CFG_IN(cfg_in), .NEW_ERROR(new_err),
      .RUN_LED_AUTO(run_auto), .ERR_LED_AUTO(err_auto), .RUN_LED_PAT(pat),
      .ERR_LED_PAT(pat), .NET_RDATA(net_rd), .HOST_RDATA(host_rd), .NET_EV_LINK_CLR(lclr),
      .NET_EV_STAT_CLR(sclr), .APP_EV_CTRL_CLR(aclr), .STATE_REQ(st_req), .ERR_ACK(err_ack),
      .STATE_ACT(st_act), .MAILBOX_LOCKED(locked), .RUN_LED(run_led), .ERR_LED(err_led),
      .MIRROR_EN(mirror), .SYNC_OUT_EN(sync_en), .LATCH_IN_EN(latch_en), .ENH_LINK_EN(enh),
      .HOST_SEL(sel));
   lasr_far_model far (.CLK(clk), .NET_RDATA(net_rd), .HOST_RDATA(host_rd),
      .NET_REQ(net_req), .HOST_REQ(host_req));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic rst(input logic [7:0] s, input logic [7:0] c, input int n);
      @(posedge clk);
      #1;
      rst_n = 0;
      sel_in = s;
      cfg_in = c;
      repeat (n) @(posedge clk);
      #1 rst_n = 1;
      @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] link_exp(input lasr_pkg::lasr_port_t p);
      logic [15:0] e;
      e = {8'h00, p.link, 4'h0};
      for (int i = 0; i < 4; i++) begin
         e[8+2*i] = p.loop_closed[i];
         e[9+2*i] = p.comm_ok[i];
      end
      return {e[15:4], 4'h0};
   endfunction
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   initial begin
      #(20000 * 100);
      n_errors++;
      end_sim();
   end
   initial begin
      {rst_n, new_err, run_auto, err_auto, port_st} = '0;
      pat = 4'h1;
      rst(8'h05, 8'h00, 10);
      far.acc(0, 0, 16'h0120, 2'b11, 16'h0000, q);
      chk("ctrl reset", q, 16'h0001);
      far.acc(0, 0, 16'h0130, 2'b11, 16'h0000, q);
      chk("status reset", q, 16'h0001);
      far.acc(0, 0, 16'h0134, 2'b11, 16'h0000, q);
      chk("code reset", q, 16'h0000);
      far.acc(0, 0, 16'h0200, 2'b11, 16'h0000, q);
      chk("unmapped", q, 16'h0000);
      foreach (pats[i]) begin
         port_st = pats[i];
         far.acc(1, 0, 16'h0110, 2'b11, 16'h0000, q);
         chk("link status", {q[15:4], 4'h0}, link_exp(pats[i]));
      end
      $display("test reset and link done");
      foreach (sts[i]) begin
         far.acc(1, 1, 16'h0120, 2'b11, {11'h0, 1'b1, sts[i]}, q);
         chk("request", 16'(st_req), 16'(sts[i]));
         chk("ack", 16'(err_ack), 16'h0001);
         chk("locked", 16'(locked), 16'h0001);
         far.acc(1, 1, 16'h0120, 2'b11, 16'(sts[i] ^ 4'hC), q);
         chk("kept", 16'(st_req), 16'(sts[i]));
         far.acc(0, 0, i[0] ? 16'h0121 : 16'h0120, 2'b11, 16'h0000, q);
         if (!i[0]) chk("ctrl read", q, {11'h0, 1'b1, sts[i]});
         chk("unlocked", 16'(locked), 16'h0000);
      end
      $display("test mailbox done");
      far.acc(0, 1, 16'h0138, 2'b11, 16'h1F1F, q);
      repeat (3) @(posedge clk);
      #1;
      chk("leds on", 16'({run_led, err_led}), 16'h0003);
      far.acc(0, 0, 16'h0138, 2'b11, 16'h0000, q);
      chk("override read", q & 16'h0101, 16'h0101);
      pat = 4'h0;
      repeat (2) @(posedge clk);
      #1;
      chk("leds pattern", 16'({run_led, err_led}), 16'h0000);
      pat = 4'h1;
      far.acc(0, 1, 16'h0130, 2'b11, 16'h0014, q);
      new_err = 1;
      @(posedge clk);
      #1 new_err = 0;
      repeat (3) @(posedge clk);
      #1;
      chk("leds off", 16'({run_led, err_led}), 16'h0000);
      far.acc(1, 0, 16'h0130, 2'b11, 16'h0000, q);
      chk("status", q, 16'h0014);
      far.acc(0, 1, 16'h0134, 2'b11, 16'hBEEF, q);
      far.acc(1, 1, 16'h0134, 2'b11, 16'h1234, q);
      far.acc(1, 0, 16'h0134, 2'b11, 16'h0000, q);
      chk("code", q, 16'hBEEF);
      $display("test status and indicators done");
      foreach (codes[i]) begin
         rst(codes[i], 8'h2D, 2);
         chk("select", 16'(sel), 16'(codes[i]));
      end
      chk("config", 16'({enh, latch_en, sync_en, mirror}), 16'h0017);
      far.acc(1, 1, 16'h0120, 2'b11, 16'h0004, q);
      far.acc(1, 1, 16'h0120, 2'b11, 16'h0008, q);
      chk("mirror req", 16'(st_req), 16'h0008);
      far.acc(0, 1, 16'h0130, 2'b11, 16'h0002, q);
      far.acc(1, 0, 16'h0130, 2'b11, 16'h0000, q);
      chk("mirror status", q, 16'h0008);
      rst(8'h00, 8'h02, 2);
      chk("all ports", 16'(enh), 16'h000F);
      $display("test configuration done");
      end_sim();
   end
endmodule
